// >>> verilog/ctam_pkg.sv
package ctam_pkg;

    // ----------------------------------------------------------------
    // Line indices and line count
    // ----------------------------------------------------------------
    localparam int CTAM_LINES     = 2;
    localparam int CTAM_LINE_A    = 0;   // First internal cross line
    localparam int CTAM_LINE_B    = 1;   // Second internal cross line

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] CTAM_ROUTE_RST  = 2'h0;   // Nothing routed
    localparam logic       CTAM_ARMED_RST  = 1'h0;
    localparam logic       CTAM_HOLD_RST   = 1'h0;
    localparam logic       CTAM_PIN_IDLE   = 1'h1;   // Active-low trigger pin idle level
    localparam logic [1:0] CTAM_SYNC_RST   = 2'h3;   // Synchroniser idle (pin high)

    // Arm tracking states
    typedef enum logic [2:0] {
        CTAM_ARM_FREE  = 3'h1,   // No arm routing: always armed
        CTAM_ARM_WAIT  = 3'h2,   // Routed, waiting for an arm event
        CTAM_ARM_HELD  = 3'h4    // Routed and armed
    } ctam_arm_type;

endpackage

// >>> verilog/ctam_matrix.sv
`timescale 1ns/1ps
module ctam_matrix
    import ctam_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // Per-line routing, bit index is the line
    input  wire logic [1:0] INT_DRIVE_EN,
    input  wire logic [1:0] INT_ARM_EN,
    input  wire logic [1:0] EXT_DRIVE_EN,
    input  wire logic [1:0] EXT_ARM_EN,
    input  wire logic [1:0] BREAK_EN,
    input  wire logic [1:0] BUS_DRIVE_EN,
    input  wire logic [1:0] BUS_RECV_EN,
    input  wire logic [1:0] COAX_DRIVE_EN,
    input  wire logic [1:0] COAX_RECV_EN,
    // Analyzer and emulator events, same clock domain
    input  wire logic       INT_TRIG,
    input  wire logic       EXT_TRIG,
    input  wire logic       EXT_TIMING_MODE,
    input  wire logic       TRACE_START,
    input  wire logic       TRACE_HALT,
    input  wire logic       EMU_IN_MONITOR,
    // Trigger pins, active low, open drain
    input  wire logic       BUS_TRIG_N_IN,
    output logic            BUS_TRIG_N_OUT,
    output logic            BUS_TRIG_N_OE,
    input  wire logic       COAX_TRIG_N_IN,
    output logic            COAX_TRIG_N_OUT,
    output logic            COAX_TRIG_N_OE,
    // Results toward analyzers and emulator
    output logic            INT_ARMED,
    output logic            EXT_ARMED,
    output logic            INT_TRACE_ALLOW,
    output logic            EXT_TRACE_ALLOW,
    output logic            EXT_TIMING_GO,
    output logic            EMU_BREAK,
    output logic [1:0]      LINE_STATE
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] bus_sync;
    logic [1:0] coax_sync;

    // Two stages before any logic reads a pin
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bus_sync  <= CTAM_SYNC_RST;
            coax_sync <= CTAM_SYNC_RST;
        end else begin
            bus_sync  <= {bus_sync[0], BUS_TRIG_N_IN};
            coax_sync <= {coax_sync[0], COAX_TRIG_N_IN};
        end
    end

    // ----------------------------------------------------------------
    // Analyzer trigger hold
    // ----------------------------------------------------------------
    logic       int_hold;
    logic       ext_hold;
    logic       int_first;
    logic       ext_first;
    logic       brk_rise;
    logic       brk_prev;
    logic [1:0] int_brk_line;
    logic [1:0] ext_brk_line;
    logic [1:0] shared_drive;
    logic       next_int_hold;
    logic       next_ext_hold;

    // Incoming external triggers, active low on the pins
    wire bus_in  = ~bus_sync[1];
    wire coax_in = ~coax_sync[1];

    // Lines that both analyzers may drive
    assign shared_drive = INT_DRIVE_EN & EXT_DRIVE_EN;

    // First analyzer to trigger takes a shared line; the other is then blocked on its unshared lines too
    assign int_first = INT_TRIG & ~(ext_hold & |shared_drive);
    assign ext_first = EXT_TRIG & ~(int_hold & |shared_drive);

    // Break entry edge from the emulator
    assign brk_rise = EMU_IN_MONITOR & ~brk_prev;

    // Lines whose break came from the given analyzer
    assign int_brk_line = INT_DRIVE_EN & BREAK_EN;
    assign ext_brk_line = EXT_DRIVE_EN & BREAK_EN;

    // Trigger latched until halt, restart or its own break; a fresh trigger beats the break
    assign next_int_hold = (TRACE_START | TRACE_HALT) ? CTAM_HOLD_RST :
                           int_first                  ? 1'h1 :
                           (brk_rise & |int_brk_line) ? CTAM_HOLD_RST :
                           int_hold;
    assign next_ext_hold = (TRACE_START | TRACE_HALT) ? CTAM_HOLD_RST :
                           ext_first                  ? 1'h1 :
                           (brk_rise & |ext_brk_line) ? CTAM_HOLD_RST :
                           ext_hold;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            int_hold <= CTAM_HOLD_RST;
            ext_hold <= CTAM_HOLD_RST;
            brk_prev <= CTAM_HOLD_RST;
        end else begin
            int_hold <= next_int_hold;
            ext_hold <= next_ext_hold;
            brk_prev <= EMU_IN_MONITOR;
        end
    end

    // ----------------------------------------------------------------
    // Internal cross lines
    // ----------------------------------------------------------------
    logic [1:0] line;
    logic [1:0] int_src;
    logic [1:0] ext_src;

    // Analyzer drive per line; a break on any of its break lines stops the hold on all lines
    assign int_src = INT_DRIVE_EN & {2{int_hold | int_first}};
    assign ext_src = EXT_DRIVE_EN & {2{ext_hold | ext_first}};

    genvar gi;
    generate
        for (gi = 0; gi < CTAM_LINES; gi++) begin : g_line
            // Each line is the OR of its enabled sources
            assign line[gi] = int_src[gi] | ext_src[gi]
                            | (BUS_RECV_EN[gi] & bus_in)
                            | (COAX_RECV_EN[gi] & coax_in);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Sink decode
    // ----------------------------------------------------------------
    logic bus_drive;
    logic coax_drive;
    logic int_arm_ev;
    logic ext_arm_ev;
    logic brk_req;

    // Pin drive excludes the pin's own echo so a received level cannot latch
    assign bus_drive  = |(BUS_DRIVE_EN & (int_src | ext_src
                        | (COAX_RECV_EN & {2{coax_in}})));
    assign coax_drive = |(COAX_DRIVE_EN & (int_src | ext_src
                        | (BUS_RECV_EN & {2{bus_in}})));
    assign int_arm_ev = |(INT_ARM_EN & line);
    assign ext_arm_ev = |(EXT_ARM_EN & line);
    assign brk_req    = |(BREAK_EN & line);

    // ----------------------------------------------------------------
    // Arm tracking, one machine per analyzer
    // ----------------------------------------------------------------
    ctam_arm_type int_st;
    ctam_arm_type ext_st;
    ctam_arm_type next_int_st;
    ctam_arm_type next_ext_st;

    // Arm state from routing, arm events and trace restart
    function automatic ctam_arm_type arm_next(input ctam_arm_type st,
                                               input logic routed,
                                               input logic ev,
                                               input logic restart);
        ctam_arm_type r;
        r = st;
        unique case (st)
            CTAM_ARM_FREE: begin
                if (routed) begin
                    r = ev ? CTAM_ARM_HELD : CTAM_ARM_WAIT;
                end
            end
            CTAM_ARM_WAIT: begin
                if (!routed) begin
                    r = CTAM_ARM_FREE;
                end else if (ev) begin
                    r = CTAM_ARM_HELD;
                end
            end
            CTAM_ARM_HELD: begin
                if (!routed) begin
                    r = CTAM_ARM_FREE;
                end else if (restart && !ev) begin
                    r = CTAM_ARM_WAIT;
                end
            end
            default: begin
                r = CTAM_ARM_FREE;
            end
        endcase
        return r;
    endfunction

    assign next_int_st = arm_next(int_st, |INT_ARM_EN, int_arm_ev, TRACE_START);
    assign next_ext_st = arm_next(ext_st, |EXT_ARM_EN, ext_arm_ev, TRACE_START);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            int_st <= CTAM_ARM_FREE;
            ext_st <= CTAM_ARM_FREE;
        end else begin
            int_st <= next_int_st;
            ext_st <= next_ext_st;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    logic next_int_armed;
    logic next_ext_armed;
    logic ext_armed_q;

    // Armed unless waiting for a routed arm event
    assign next_int_armed = (next_int_st != CTAM_ARM_WAIT);
    assign next_ext_armed = (next_ext_st != CTAM_ARM_WAIT);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            INT_ARMED       <= CTAM_ARMED_RST;
            EXT_ARMED       <= CTAM_ARMED_RST;
            INT_TRACE_ALLOW <= CTAM_ARMED_RST;
            EXT_TRACE_ALLOW <= CTAM_ARMED_RST;
            EXT_TIMING_GO   <= CTAM_ARMED_RST;
            ext_armed_q     <= CTAM_ARMED_RST;
            EMU_BREAK       <= CTAM_HOLD_RST;
            LINE_STATE      <= CTAM_ROUTE_RST;
            BUS_TRIG_N_OUT  <= CTAM_PIN_IDLE;
            BUS_TRIG_N_OE   <= CTAM_HOLD_RST;
            COAX_TRIG_N_OUT <= CTAM_PIN_IDLE;
            COAX_TRIG_N_OE  <= CTAM_HOLD_RST;
        end else begin
            INT_ARMED       <= next_int_armed;
            EXT_ARMED       <= next_ext_armed;
            INT_TRACE_ALLOW <= next_int_armed;
            EXT_TRACE_ALLOW <= next_ext_armed;
            ext_armed_q     <= next_ext_armed;
            // One pulse when a routed timing analyzer becomes armed
            EXT_TIMING_GO   <= EXT_TIMING_MODE & |EXT_ARM_EN
                               & next_ext_armed & ~ext_armed_q;
            EMU_BREAK       <= brk_req;
            LINE_STATE      <= line;
            BUS_TRIG_N_OUT  <= ~bus_drive;
            BUS_TRIG_N_OE   <= bus_drive;
            COAX_TRIG_N_OUT <= ~coax_drive;
            COAX_TRIG_N_OE  <= coax_drive;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_bus_follows_line: assert property (@(posedge CLK) disable iff (!RST_N)
        (BUS_DRIVE_EN[1] && int_src[1] && $stable(BUS_DRIVE_EN)) |=> BUS_TRIG_N_OE)
        else $error("bus trigger not driven by line B");

    a_pin_low_drive: assert property (@(posedge CLK) disable iff (!RST_N)
        BUS_TRIG_N_OE |-> !BUS_TRIG_N_OUT)
        else $error("bus trigger driven high");

    a_unrouted_armed: assert property (@(posedge CLK) disable iff (!RST_N)
        (INT_ARM_EN == 2'h0) |=> INT_ARMED)
        else $error("unrouted internal analyzer not armed");

    a_wait_no_trace: assert property (@(posedge CLK) disable iff (!RST_N)
        (int_st == CTAM_ARM_WAIT) |-> !INT_TRACE_ALLOW)
        else $error("trace allowed before arm");

    a_arm_on_line: assert property (@(posedge CLK) disable iff (!RST_N)
        (|INT_ARM_EN && int_arm_ev) |=> INT_ARMED)
        else $error("arm event did not arm analyzer");

    a_break_on_line: assert property (@(posedge CLK) disable iff (!RST_N)
        brk_req |=> EMU_BREAK)
        else $error("break not raised");

    a_coax_to_line: assert property (@(posedge CLK) disable iff (!RST_N)
        (COAX_RECV_EN[0] && !coax_sync[1]) |-> line[0])
        else $error("coax trigger not on line A");

    a_drop_on_break: assert property (@(posedge CLK) disable iff (!RST_N)
        (brk_rise && |int_brk_line && !INT_TRIG) |=> !int_hold)
        else $error("analyzer kept driving after break");

    a_first_wins: assert property (@(posedge CLK) disable iff (!RST_N)
        (ext_hold && !int_hold && |shared_drive) |=> !int_hold)
        else $error("second analyzer took a held line");

    a_coax_low_drive: assert property (@(posedge CLK) disable iff (!RST_N)
        COAX_TRIG_N_OE |-> !COAX_TRIG_N_OUT)
        else $error("coax trigger driven high");

    a_bus_to_line: assert property (@(posedge CLK) disable iff (!RST_N)
        (BUS_RECV_EN[1] && !bus_sync[1]) |-> line[1])
        else $error("bus trigger not on line B");

    a_trig_on_line: assert property (@(posedge CLK) disable iff (!RST_N)
        (INT_DRIVE_EN[1] && int_first) |=> LINE_STATE[1])
        else $error("analyzer trigger missing on line B");

    a_timing_go_armed: assert property (@(posedge CLK) disable iff (!RST_N)
        EXT_TIMING_GO |-> EXT_ARMED)
        else $error("timing start while not armed");

    a_no_bus_echo: assert property (@(posedge CLK) disable iff (!RST_N)
        (!(|(int_src | ext_src)) && !(|COAX_RECV_EN)) |=> !BUS_TRIG_N_OE)
        else $error("bus trigger driven by its own echo");

    a_restart_rewait: assert property (@(posedge CLK) disable iff (!RST_N)
        (TRACE_START && |INT_ARM_EN && !int_arm_ev && $stable(INT_ARM_EN)) |=> !INT_ARMED)
        else $error("restart did not drop arm");

    a_hold_cleared: assert property (@(posedge CLK) disable iff (!RST_N)
        (TRACE_START || TRACE_HALT) |=> (!int_hold && !ext_hold))
        else $error("trigger hold kept past trace boundary");

    a_ext_arm_line: assert property (@(posedge CLK) disable iff (!RST_N)
        (|EXT_ARM_EN && ext_arm_ev) |=> EXT_ARMED)
        else $error("line did not arm external analyzer");

    a_break_level: assert property (@(posedge CLK) disable iff (!RST_N)
        !brk_req |=> !EMU_BREAK)
        else $error("break raised with no line");

endmodule // ctam_matrix

// >>> dv/ctam_peer_model.sv
`timescale 1ns/1ps
// Far instrument on the measurement bus and on the coaxial connector
module ctam_peer_model (
    // Clock
    input  wire logic clk,
    // Pull requests from the bench
    input  wire logic pull_bus,
    input  wire logic pull_coax,
    // Device side of the open-drain pins
    input  wire logic bus_oe,
    input  wire logic bus_out,
    input  wire logic coax_oe,
    input  wire logic coax_out,
    // Resolved wire levels
    output logic      bus_n,
    output logic      coax_n
);
    logic bus_pull;
    logic coax_pull;

    // Peer pulls change only on a clock edge
    always_ff @(posedge clk) begin
        bus_pull  <= pull_bus;
        coax_pull <= pull_coax;
    end

    // Wired-low lines with pull-up: low while any party drives
    assign bus_n  = ~(bus_pull === 1'b1 || (bus_oe && !bus_out));
    assign coax_n = ~(coax_pull === 1'b1 || (coax_oe && !coax_out));
endmodule // ctam_peer_model

// >>> dv/test_cross_trigger_arm_matrix.sv
`timescale 1ns/1ps
module test_cross_trigger_arm_matrix;
    import ctam_pkg::*;
    logic       CLK, RST_N, EXT_TIMING_MODE, TRACE_START, TRACE_HALT, EMU_IN_MONITOR;
    logic [1:0] INT_DRIVE_EN, INT_ARM_EN, EXT_DRIVE_EN, EXT_ARM_EN, BREAK_EN;
    logic [1:0] BUS_DRIVE_EN, BUS_RECV_EN, COAX_DRIVE_EN, COAX_RECV_EN, LINE_STATE;
    logic       INT_TRIG, EXT_TRIG, BUS_TRIG_N_OUT, BUS_TRIG_N_OE, COAX_TRIG_N_OUT;
    logic       COAX_TRIG_N_OE, INT_ARMED, EXT_ARMED, INT_TRACE_ALLOW, EXT_TRACE_ALLOW;
    logic       EXT_TIMING_GO, EMU_BREAK, bus_n, coax_n, pull_bus, pull_coax;
    int         fail_count = 0;
    int         n_checks = 0;

    ctam_matrix uut (.CLK(CLK), .RST_N(RST_N), .INT_DRIVE_EN(INT_DRIVE_EN),
        .INT_ARM_EN(INT_ARM_EN), .EXT_DRIVE_EN(EXT_DRIVE_EN), .EXT_ARM_EN(EXT_ARM_EN),
        .BREAK_EN(BREAK_EN), .BUS_DRIVE_EN(BUS_DRIVE_EN), .BUS_RECV_EN(BUS_RECV_EN),
        .COAX_DRIVE_EN(COAX_DRIVE_EN), .COAX_RECV_EN(COAX_RECV_EN), .INT_TRIG(INT_TRIG),
        .EXT_TRIG(EXT_TRIG), .EXT_TIMING_MODE(EXT_TIMING_MODE), .TRACE_START(TRACE_START),
        .TRACE_HALT(TRACE_HALT), .EMU_IN_MONITOR(EMU_IN_MONITOR), .BUS_TRIG_N_IN(bus_n),
        .BUS_TRIG_N_OUT(BUS_TRIG_N_OUT), .BUS_TRIG_N_OE(BUS_TRIG_N_OE),
        .COAX_TRIG_N_IN(coax_n), .COAX_TRIG_N_OUT(COAX_TRIG_N_OUT),
        .COAX_TRIG_N_OE(COAX_TRIG_N_OE), .INT_ARMED(INT_ARMED), .EXT_ARMED(EXT_ARMED),
        .INT_TRACE_ALLOW(INT_TRACE_ALLOW), .EXT_TRACE_ALLOW(EXT_TRACE_ALLOW),
        .EXT_TIMING_GO(EXT_TIMING_GO), .EMU_BREAK(EMU_BREAK), .LINE_STATE(LINE_STATE));

    ctam_peer_model peer (.clk(CLK), .pull_bus(pull_bus), .pull_coax(pull_coax),
        .bus_oe(BUS_TRIG_N_OE), .bus_out(BUS_TRIG_N_OUT), .coax_oe(COAX_TRIG_N_OE),
        .coax_out(COAX_TRIG_N_OUT), .bus_n(bus_n), .coax_n(coax_n));

    // Clock generation
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // Step n edges, then settle just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    // Compare and count
    task automatic chk(input string name, input logic [1:0] exp, input logic [1:0] seen);
        n_checks++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    // Verdict and end of run
    task automatic print_verdict;
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Return routing to idle and clear any holds
    task automatic clean;
        {INT_DRIVE_EN, INT_ARM_EN, EXT_DRIVE_EN, EXT_ARM_EN, BREAK_EN} = 10'h000;
        {BUS_DRIVE_EN, BUS_RECV_EN, COAX_DRIVE_EN, COAX_RECV_EN} = 8'h00;
        {INT_TRIG, EXT_TRIG, EXT_TIMING_MODE, EMU_IN_MONITOR, pull_bus, pull_coax} = 6'h00;
        TRACE_HALT = 1'b1;
        tick(1);
        TRACE_HALT = 1'b0;
        tick(6);
    endtask

    // Pulse one analyzer trigger for one cycle
    task automatic fire(input logic ext);
        if (ext) EXT_TRIG = 1'b1; else INT_TRIG = 1'b1;
        tick(1);
        {INT_TRIG, EXT_TRIG} = 2'h0;
    endtask

    // Idle after reset: free-armed, bus pin released
    task automatic t_idle;
        chk("int_armed", 2'h1, INT_ARMED);
        chk("ext_armed", 2'h1, EXT_ARMED);
        chk("bus_oe", 2'h0, BUS_TRIG_N_OE);
        chk("bus_out", 2'h1, BUS_TRIG_N_OUT);
    endtask

    // Trigger on line B to bus while coax breaks on line A
    task automatic t_bus_hold;
        INT_DRIVE_EN = 2'h2; BUS_DRIVE_EN = 2'h2;
        COAX_RECV_EN = 2'h1; BREAK_EN = 2'h1;
        tick(1);
        fire(1'b0);
        tick(1);
        chk("line_state", 2'h2, LINE_STATE);
        chk("bus_wire", 2'h0, bus_n);
        pull_coax = 1'b1;
        tick(6);
        chk("emu_break", 2'h1, EMU_BREAK);
        pull_coax = 1'b0;
        EMU_IN_MONITOR = 1'b1;
        tick(6);
        chk("bus_oe_kept", 2'h1, BUS_TRIG_N_OE);
        TRACE_HALT = 1'b1;
        tick(1);
        TRACE_HALT = 1'b0;
        tick(2);
        chk("bus_oe_halt", 2'h0, BUS_TRIG_N_OE);
        clean();
    endtask

    // Shared break and bus line released after the break
    task automatic t_break_release;
        INT_DRIVE_EN = 2'h2; BUS_DRIVE_EN = 2'h2; BREAK_EN = 2'h2;
        tick(1);
        fire(1'b0);
        tick(1);
        chk("emu_break", 2'h1, EMU_BREAK);
        chk("bus_oe_on", 2'h1, BUS_TRIG_N_OE);
        EMU_IN_MONITOR = 1'b1;
        tick(3);
        chk("bus_oe_off", 2'h0, BUS_TRIG_N_OE);
        chk("line_b_free", 2'h0, LINE_STATE);
        clean();
    endtask

    // Bus trigger arms the internal analyzer over line B
    task automatic t_bus_arm;
        INT_ARM_EN = 2'h2; BUS_RECV_EN = 2'h2;
        tick(2);
        chk("int_armed_wait", 2'h0, INT_ARMED);
        chk("int_allow_wait", 2'h0, INT_TRACE_ALLOW);
        pull_bus = 1'b1;
        tick(6);
        chk("line_b_rx", 2'h2, LINE_STATE);
        chk("int_armed", 2'h1, INT_ARMED);
        chk("int_allow", 2'h1, INT_TRACE_ALLOW);
        clean();
    endtask

    // Coax arms the timing analyzer over line A
    task automatic t_coax_timing;
        int pulses;
        pulses = 0;
        EXT_ARM_EN = 2'h1; COAX_RECV_EN = 2'h1; EXT_TIMING_MODE = 1'b1;
        tick(2);
        chk("ext_armed_wait", 2'h0, EXT_ARMED);
        pull_coax = 1'b1;
        for (int i = 0; i < 10; i++) begin
            tick(1);
            if (EXT_TIMING_GO === 1'b1) pulses++;
        end
        chk("timing_go", 2'h1, 2'(pulses));
        chk("line_a_rx", 2'h1, LINE_STATE);
        chk("ext_armed", 2'h1, EXT_ARMED);
        clean();
    endtask

    // One analyzer arms the other, both ways
    task automatic t_cross_arm;
        EXT_DRIVE_EN = 2'h1; INT_ARM_EN = 2'h1;
        tick(2);
        chk("int_armed_wait", 2'h0, INT_ARMED);
        fire(1'b1);
        tick(2);
        chk("int_armed_x", 2'h1, INT_ARMED);
        clean();
        INT_DRIVE_EN = 2'h2; EXT_ARM_EN = 2'h2;
        tick(2);
        chk("ext_allow_wait", 2'h0, EXT_TRACE_ALLOW);
        fire(1'b0);
        tick(2);
        chk("ext_armed_x", 2'h1, EXT_ARMED);
        clean();
    endtask

    // External trigger arms the internal one, which then drives the bus
    task automatic t_arm_then_drive;
        EXT_DRIVE_EN = 2'h1; INT_ARM_EN = 2'h1; COAX_DRIVE_EN = 2'h1;
        INT_DRIVE_EN = 2'h2; BUS_DRIVE_EN = 2'h2;
        tick(1);
        fire(1'b1);
        tick(1);
        fire(1'b0);
        tick(1);
        chk("line_both", 2'h3, LINE_STATE);
        chk("bus_oe_armed", 2'h1, BUS_TRIG_N_OE);
        chk("coax_wire", 2'h0, coax_n);
        TRACE_START = 1'b1;
        tick(1);
        TRACE_START = 1'b0;
        tick(2);
        chk("bus_oe_start", 2'h0, BUS_TRIG_N_OE);
        chk("coax_oe_start", 2'h0, COAX_TRIG_N_OE);
        TRACE_START = 1'b1;
        tick(1);
        TRACE_START = 1'b0;
        tick(1);
        chk("int_armed_rst", 2'h0, INT_ARMED);
        chk("int_allow_rst", 2'h0, INT_TRACE_ALLOW);
        INT_DRIVE_EN = 2'h3;
        fire(1'b1);
        tick(1);
        fire(1'b0);
        tick(1);
        chk("line_first", 2'h1, LINE_STATE);
        clean();
    endtask

    // Bus both driven and received on line B feeding the break
    task automatic t_bidir_break;
        BUS_DRIVE_EN = 2'h2; BUS_RECV_EN = 2'h2; BREAK_EN = 2'h2;
        pull_bus = 1'b1;
        tick(6);
        chk("emu_break_rx", 2'h1, EMU_BREAK);
        chk("bus_no_echo", 2'h0, BUS_TRIG_N_OE);
        clean();
    endtask

    // Main sequence
    initial begin
        RST_N = 1'b0;
        {INT_DRIVE_EN, INT_ARM_EN, EXT_DRIVE_EN, EXT_ARM_EN, BREAK_EN} = 10'h000;
        {BUS_DRIVE_EN, BUS_RECV_EN, COAX_DRIVE_EN, COAX_RECV_EN} = 8'h00;
        {INT_TRIG, EXT_TRIG, EXT_TIMING_MODE, EMU_IN_MONITOR, pull_bus, pull_coax} = 6'h00;
        {TRACE_START, TRACE_HALT} = 2'h0;
        tick(3);
        RST_N = 1'b1;
        tick(2);
        t_idle();
        t_bus_hold();
        t_break_release();
        t_bus_arm();
        t_coax_timing();
        t_cross_arm();
        t_arm_then_drive();
        t_bidir_break();
        print_verdict();
    end
endmodule // test_cross_trigger_arm_matrix
